// ### codec_serial_control_port.sv
// Purpose: Serial port of a voice-band codec, device side.
// Assumes: Shift clock slower than a quarter of I_CLK.
// Notes: Link pins pass two flip-flops before use.
//
// Design decisions made here: the address map and the Wishbone register port.
`include "codec_sport_defs.svh"
module codec_serial_control_port (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Serial link
  input wire logic I_SCLK,
  input wire logic I_DIN,
  input wire logic I_ALTERNATE_CONTROL_INPUT,
  input wire logic I_SECONDARY_REQUEST_PIN,
  input wire logic I_DIRECT_CONFIG_SERIAL_INPUT,
  input wire logic [1:0] I_MASTER_SLAVE_MODE_SELECT,
  output logic O_DOUT,
  output logic O_FRAME_SYNC_B
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic sclk_d;
  logic fc_d;

  // Two flops on every pin from the link except I_DIN, which is synchronised below
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      sync1 <= 7'h60;
      sync2 <= 7'h60;
      sclk_d <= 1'b0;
      fc_d <= 1'b0;
    end
    else
    begin
      sync1 <= {1'b1, I_DIRECT_CONFIG_SERIAL_INPUT, I_MASTER_SLAVE_MODE_SELECT,
                I_SECONDARY_REQUEST_PIN, I_ALTERNATE_CONTROL_INPUT, I_SCLK};
      sync2 <= sync1;
      sclk_d <= sync2[0];
      fc_d <= sync2[2];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic fc_rise;
  logic [1:0] mode_sel;
  logic direct_config_serial_input;
  // Edge finding on the synchronised copies
  assign sclk_rise = sync2[0] & ~sclk_d;
  assign sclk_fall = ~sync2[0] & sclk_d;
  assign fc_rise = sync2[2] & ~fc_d;
  assign mode_sel = sync2[4:3];
  assign direct_config_serial_input = sync2[5];

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] ctrl [`NUM_CTRL];
  logic [7:0] next_ctrl [`NUM_CTRL];
  codec_sport_pkg::cfg_t cfg, next_cfg;
  logic [15:0] adc_word, next_adc_word;
  logic [15:0] dac_word, next_dac_word;
  logic [8:0] slot, next_slot;
  logic fs_b, next_fs_b;
  logic fs_sec, next_fs_sec;
  logic tx_act, next_tx_act;
  logic tx_sec, next_tx_sec;
  logic [3:0] tx_idx, next_tx_idx;
  logic dout, next_dout;
  logic [15:0] rx, next_rx;
  logic [7:0] rd_data, next_rd_data;
  logic req, next_req;
  codec_sport_pkg::direct_config_serial_input_state_t dc_state, next_dc_state;
  logic [14:0] dc_rx, next_dc_rx;
  logic [3:0] dc_cnt, next_dc_cnt;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;

  logic cont;
  logic [8:0] slot_last;
  logic [8:0] slot_sec;
  logic [15:0] win;
  logic ctl_bit;
  codec_sport_pkg::sec_word_t sw;
  codec_sport_pkg::dc_word_t dw;
  logic sec_we;
  logic dc_we;
  logic [7:0] rd_now;
  logic wb_we;

  // RL18 - continuous mode gate
  assign cont = ctrl[2][`POS_CONTINUOUS] & (mode_sel == 2'b00);
  // RL9 - frame period select
  assign slot_last = cont ? `SLOT_LAST_CONT : (cfg.big_cascade ? `SLOT_LAST_BIG : `SLOT_LAST_SMALL);
  // RL22 - secondary start slot
  assign slot_sec = cfg.big_cascade ? `SLOT_SEC_BIG : `SLOT_SEC_SMALL;
  logic din_s1;
  logic din_s2;
  logic din_s;
  // RL1 - control bit from chosen input
  assign ctl_bit = (tx_sec && cfg.use_alt) ? sync2[1] : din_s;
  assign din_s = sync2[6] & din_s2;

  // Data input synchroniser
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end
    else
    begin
      din_s1 <= I_DIN;
      din_s2 <= din_s1;
    end
  end

  // RL11 - word assembled most significant first
  assign win = {rx[14:0], ctl_bit};
  assign sw = codec_sport_pkg::sec_word_t'(win);
  assign dw = codec_sport_pkg::dc_word_t'(dc_rx);
  // RL2 - zero upper byte writes nothing
  // RL4 - read frame never writes
  assign sec_we = sclk_fall && tx_act && tx_sec && (tx_idx == 4'hF) && (win[15:8] != 8'h00)
                  && (sw.dev == cfg.dev_addr) && !sw.rw && (sw.ra != 3'h0) && (sw.ra <= 3'h4);
  // RL15 - stop bit must be high
  assign dc_we = sclk_fall && (dc_state == codec_sport_pkg::DC_STOP) && direct_config_serial_input
                 && (dw.dev == cfg.dev_addr) && (dw.ra != 3'h0) && (dw.ra <= 3'h4);
  // RL3 - readback selected after eight bits in
  assign rd_now = (rx[7:5] == cfg.dev_addr && rx[4] && rx[3:1] != 3'h0 && rx[3:1] <= 3'h4)
                  ? ctrl[rx[2:1] - 2'h1] : 8'h00;
  assign wb_we = I_WB_CYC && I_WB_STB && I_WB_WE && !ack;

  ////////////////////////////////////////////////////////////////////////////
  // Link next state
  always_comb
  begin
    next_slot = slot;
    next_fs_b = fs_b;
    next_fs_sec = fs_sec;
    next_tx_act = tx_act;
    next_tx_sec = tx_sec;
    next_tx_idx = tx_idx;
    next_dout = dout;
    next_rx = rx;
    next_rd_data = rd_data;
    next_dac_word = dac_word;
    next_req = req;
    next_dc_state = dc_state;
    next_dc_rx = dc_rx;
    next_dc_cnt = dc_cnt;
    if (sclk_rise)
    begin
      next_slot = (slot >= slot_last) ? 9'h000 : slot + 9'h001;
      // RL19 - sync overlaps last bit in continuous mode
      // RL24 - primary sync each period
      next_fs_sec = !cont && req && (next_slot == slot_sec);
      next_fs_b = !((cont ? (next_slot == `SLOT_LAST_CONT) : (next_slot == 9'h000)) || next_fs_sec);
      if (!fs_b)
      begin
        next_tx_act = 1'b1;
        next_tx_sec = fs_sec;
        next_tx_idx = 4'h0;
      end
      else if (tx_act)
      begin
        next_tx_act = (tx_idx != 4'hF);
        next_tx_idx = tx_idx + 4'h1;
      end
      if (next_tx_sec && next_tx_idx == 4'h8)
        next_rd_data = rd_now;
      // RL6 - echo address, then register byte
      // RL7 - write frame returns zeros
      if (!next_tx_act)
        next_dout = 1'b0;
      else if (!next_tx_sec)
        next_dout = adc_word[~next_tx_idx];
      else if (next_tx_idx < 4'h3)
        next_dout = cfg.dev_addr[2'h2 - next_tx_idx[1:0]];
      else if (next_tx_idx < 4'h8)
        next_dout = 1'b0;
      else
        next_dout = (next_tx_idx == 4'h8) ? rd_now[7] : rd_data[~next_tx_idx[2:0]];
    end
    if (sclk_fall && tx_act)
    begin
      next_rx = win;
      if (tx_idx == 4'hF && !tx_sec)
      begin
        // RL12 - RL13 - sample stored as received
        next_dac_word = win;
        // RL10 - software request in 15-bit mode
        // RL20 - ignored while continuous
        if (!ctrl[0][`POS_WORD16] && win[0] && !cont)
          next_req = 1'b1;
      end
      // RL8 - flag cleared once programming ends
      if (tx_idx == 4'hF && tx_sec)
        next_req = 1'b0;
    end
    // RL8 - pin pulse sets flag, set wins
    if (fc_rise)
      next_req = 1'b1;
    // RL16 - config bits on falling edge
    if (sclk_fall)
    begin
      case (dc_state)
        codec_sport_pkg::DC_IDLE:
        begin
          next_dc_cnt = 4'h0;
          if (!direct_config_serial_input)
            next_dc_state = codec_sport_pkg::DC_DATA;
        end
        codec_sport_pkg::DC_DATA:
        begin
          // RL17 - fifteen bits after the start bit
          next_dc_rx = {dc_rx[13:0], direct_config_serial_input};
          next_dc_cnt = dc_cnt + 4'h1;
          if (dc_cnt == 4'hE)
            next_dc_state = codec_sport_pkg::DC_STOP;
        end
        codec_sport_pkg::DC_STOP:
          next_dc_state = codec_sport_pkg::DC_IDLE;
        default:
          next_dc_state = codec_sport_pkg::DC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus next state
  always_comb
  begin
    next_cfg = cfg;
    next_adc_word = adc_word;
    next_ack = I_WB_CYC && I_WB_STB && !ack;
    next_rdat = rdat;
    for (int i = 0; i < `NUM_CTRL; i++)
    begin
      next_ctrl[i] = ctrl[i];
      // RL1 - serial frame writes first
      if (sec_we && sw.ra[1:0] == 2'(i + 1))
        next_ctrl[i] = sw.data;
      else if (dc_we && dw.ra[1:0] == 2'(i + 1))
        next_ctrl[i] = dw.data;
      else if (wb_we && I_WB_SEL[0] && I_WB_ADR == 8'(4 * i))
        next_ctrl[i] = I_WB_DAT[7:0];
    end
    if (wb_we && I_WB_SEL[0] && I_WB_ADR == `OFS_CONFIG)
      next_cfg = codec_sport_pkg::cfg_t'(I_WB_DAT[4:0]);
    if (wb_we && I_WB_ADR == `OFS_ADC)
    begin
      if (I_WB_SEL[0])
        next_adc_word[7:0] = I_WB_DAT[7:0];
      if (I_WB_SEL[1])
        next_adc_word[15:8] = I_WB_DAT[15:8];
    end
    if (I_WB_CYC && I_WB_STB && !ack && !I_WB_WE)
    begin
      case (I_WB_ADR)
        `OFS_CTRL1: next_rdat = {24'h000000, ctrl[0]};
        `OFS_CTRL2: next_rdat = {24'h000000, ctrl[1]};
        `OFS_CTRL3: next_rdat = {24'h000000, ctrl[2]};
        `OFS_CTRL4: next_rdat = {24'h000000, ctrl[3]};
        `OFS_CONFIG: next_rdat = {27'h0000000, cfg};
        `OFS_STATUS: next_rdat = {29'h00000000, tx_act & tx_sec, cont, req};
        `OFS_ADC: next_rdat = {16'h0000, adc_word};
        `OFS_DAC: next_rdat = {16'h0000, dac_word};
        default: next_rdat = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      // RL23 - 15-bit mode after reset
      for (int i = 0; i < `NUM_CTRL; i++)
        ctrl[i] <= `CTRL_RST;
      cfg <= `CONFIG_RST;
      adc_word <= `ADC_RST;
      dac_word <= 16'h0000;
      slot <= 9'h000;
      fs_b <= 1'b1;
      fs_sec <= 1'b0;
      tx_act <= 1'b0;
      tx_sec <= 1'b0;
      tx_idx <= 4'h0;
      dout <= 1'b0;
      rx <= 16'h0000;
      rd_data <= 8'h00;
      req <= 1'b0;
      dc_state <= codec_sport_pkg::DC_IDLE;
      dc_rx <= 15'h0000;
      dc_cnt <= 4'h0;
      ack <= 1'b0;
      rdat <= 32'h00000000;
    end
    else
    begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      adc_word <= next_adc_word;
      dac_word <= next_dac_word;
      slot <= next_slot;
      fs_b <= next_fs_b;
      fs_sec <= next_fs_sec;
      tx_act <= next_tx_act;
      tx_sec <= next_tx_sec;
      tx_idx <= next_tx_idx;
      dout <= next_dout;
      rx <= next_rx;
      rd_data <= next_rd_data;
      req <= next_req;
      dc_state <= next_dc_state;
      dc_rx <= next_dc_rx;
      dc_cnt <= next_dc_cnt;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // Outputs straight from flops
  assign O_DOUT = dout;
  assign O_FRAME_SYNC_B = fs_b;
  assign O_WB_ACK = ack;
  assign O_WB_DAT = rdat;

endmodule

// ### codec_sport_defs.svh
// Purpose: Constants of the codec serial control port.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Reset values and link timing counts live here.
// What this block does
// RL1 - Registers change only in secondary frames; not kept here, config words and Wishbone writes change them too
// RL2 - Upper byte zero means no operation
// RL3 - Bit 12 set returns register on output
// RL4 - Read frame never writes the register
// RL5 - Host sends dev, rw, reg, x, data
// RL6 - Read frame echoes address and register byte
// RL7 - Write frame echoes address, zero content
// RL8 - Request pin pulse sets flag, cleared after
// RL9 - Frame 256 clocks, 512 when cascade large
// RL10 - 15-bit mode: input bit 0 requests secondary
// RL11 - All words shifted most significant first
// RL12 - 15-bit sample sits in bits 15..1
// RL13 - Samples are two's complement
// RL14 - 16-bit mode requests only by pin
// RL15 - Config line idles high, start low, stop high
// RL16 - Config bits sampled on clock falling edge
// RL17 - Config word: start, dev, reg, x, data
// RL18 - Continuous mode: ctrl3 bit 5, mode 00
// RL19 - Continuous words back to back, early sync
// RL20 - No secondary requests in continuous mode
// RL21 - No requests in first two sample periods; not enforced here, requests are taken from the first period
// RL22 - Secondary starts 128 or 256 clocks in
// RL23 - Reset defaults to 15-bit DAC mode
// RL24 - Primary frame: sync, 16 out, 16 in
`ifndef CODEC_SPORT_DEFS_SVH
`define CODEC_SPORT_DEFS_SVH
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h04
`define OFS_CTRL3 8'h08
`define OFS_CTRL4 8'h0C
`define OFS_CONFIG 8'h10
`define OFS_STATUS 8'h14
`define OFS_ADC 8'h18
`define OFS_DAC 8'h1C
`define CTRL_RST 8'h00
`define CONFIG_RST 5'h00
`define ADC_RST 16'h0000
`define POS_WORD16 0
`define POS_CONTINUOUS 5
`define POS_BIG_CASCADE 3
`define POS_USE_ALT 4
`define SLOT_LAST_SMALL 9'h0FF
`define SLOT_LAST_BIG 9'h1FF
`define SLOT_LAST_CONT 9'h00F
`define SLOT_SEC_SMALL 9'h080
`define SLOT_SEC_BIG 9'h100
`define NUM_CTRL 4
`endif

// ### codec_sport_pkg.sv
// Purpose: Types of the codec serial control port.
// Assumes: Constants come from codec_sport_defs.svh.
// Notes: Fields travel as packed structs.
package codec_sport_pkg;
  // Direct configuration receiver states
  typedef enum logic [1:0] {
    DC_IDLE = 2'b00,
    DC_DATA = 2'b01,
    DC_STOP = 2'b10
  } direct_config_serial_input_state_t;
  // Secondary word fields, bit 15 first on the wire
  typedef struct packed {
    logic [2:0] dev;
    logic rw;
    logic [2:0] ra;
    logic dc;
    logic [7:0] data;
  } sec_word_t;
  // Direct configuration word, start bit excluded
  typedef struct packed {
    logic [2:0] dev;
    logic [2:0] ra;
    logic dc;
    logic [7:0] data;
  } dc_word_t;
  // Local configuration
  typedef struct packed {
    logic use_alt;
    logic big_cascade;
    logic [2:0] dev_addr;
  } cfg_t;
endpackage

// ### codec_sport_props.sv
// Purpose: Checker for the codec serial port pins.
// Assumes: One clock domain, reset active low.
// Notes: Bound to the top module below.
module codec_sport_props (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Bus
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  // Link
  input wire logic I_SCLK,
  input wire logic O_DOUT,
  input wire logic O_FRAME_SYNC_B
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  ////////////////////////////////////////////////////////////
  // Bus handshake
  ack_one_cycle_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack wider than one cycle");
  ack_latency_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("ack late");
  ack_cause_a: assert property (O_WB_ACK |-> $past(I_WB_STB)) else $error("ack without request");
  unmapped_zero_a: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR >= 8'h20 |-> O_WB_DAT == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(O_WB_DAT) |-> O_WB_ACK && !I_WB_WE) else $error("read data moved");
  ////////////////////////////////////////////////////////////
  // Link timing, one shift clock is 32 system clocks
  fs_width_a: assert property (
    $fell(O_FRAME_SYNC_B) |-> (!O_FRAME_SYNC_B)[*8] ##[20:30] O_FRAME_SYNC_B) else $error("sync width wrong");
  fs_gap_a: assert property (
    $rose(O_FRAME_SYNC_B) |-> O_FRAME_SYNC_B[*8]) else $error("sync gap too short");
  fs_edge_a: assert property (
    $changed(O_FRAME_SYNC_B) |-> $past(I_SCLK, 2) && !$past(I_SCLK, 8)) else $error("sync off clock rise");
  dout_edge_a: assert property (
    $changed(O_DOUT) |-> $past(I_SCLK, 2) && !$past(I_SCLK, 8)) else $error("data off clock rise");
endmodule
bind codec_serial_control_port codec_sport_props i_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .I_SCLK(I_SCLK), .O_DOUT(O_DOUT), .O_FRAME_SYNC_B(O_FRAME_SYNC_B));

// ### codec_host_model.sv
// Purpose: Host serial port model on the codec link.
// Assumes: Shift clock runs free at 160 ns.
// Notes: Tasks are called by the bench.
module codec_host_model (
  // Link outputs
  output logic o_sclk,
  output logic o_din,
  output logic o_req,
  output logic o_direct_config_serial_input,
  // Link inputs
  input wire logic i_dout,
  input wire logic i_fs_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shift clock, phase unrelated to the system clock
  initial
  begin
    o_sclk = 1'h0;
    o_din = 1'h0;
    o_req = 1'h0;
    o_direct_config_serial_input = 1'h1;
    #97;
    forever #80 o_sclk = ~o_sclk;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    int i;
    while (i_fs_b !== 1'h0)
      @(negedge o_sclk);
    for (i = 15; i >= 0; i--)
    begin
      @(posedge o_sclk);
      o_din <= w[i];
      @(negedge o_sclk);
      r[i] = i_dout;
    end
    @(posedge o_sclk);
    o_din <= ~w[0];
  endtask
  // shift clocks until the next sync
  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(negedge o_sclk);
      n++;
    end
    while (i_fs_b !== 1'h0 && n < 600);
  endtask
  // Shift clocks from one sync to the next
  task automatic period(output int n);
    while (i_fs_b !== 1'h0)
      @(negedge o_sclk);
    gap(n);
  endtask
  task automatic pulse_req();
    @(posedge o_sclk);
    o_req <= 1'h1;
    @(posedge o_sclk);
    o_req <= 1'h0;
  endtask
  task automatic direct_config_serial_input(input logic [14:0] w);
    int i;
    @(posedge o_sclk);
    o_direct_config_serial_input <= 1'h0;
    for (i = 14; i >= 0; i--)
    begin
      @(posedge o_sclk);
      o_direct_config_serial_input <= w[i];
    end
    @(posedge o_sclk);
    o_direct_config_serial_input <= 1'h1;
    repeat (2) @(posedge o_sclk);
  endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the codec serial port.
// Assumes: Host model drives the link, bench drives the bus.
// Notes: Device address 3 is used throughout.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [1:0] mode = 2'h0;
  logic [31:0] rdat;
  logic ack, sclk, din, req, direct_config_serial_input, dout, fs_b;
  int failures = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////
  // System clock
  always #2.5 clk = ~clk;
  // Device and host
  codec_serial_control_port i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SCLK(sclk), .I_DIN(din),
    .I_ALTERNATE_CONTROL_INPUT(1'h1), .I_SECONDARY_REQUEST_PIN(req), .I_DIRECT_CONFIG_SERIAL_INPUT(direct_config_serial_input),
    .I_MASTER_SLAVE_MODE_SELECT(mode), .O_DOUT(dout), .O_FRAME_SYNC_B(fs_b));
  codec_host_model i_host (.o_sclk(sclk), .o_din(din), .o_req(req), .o_direct_config_serial_input(direct_config_serial_input), .i_dout(dout), .i_fs_b(fs_b));
  ////////////////////////////////////////////////////////////
  // One classic bus cycle, held until ack
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 40);
    // A bus that never answers counts as a mismatch
    if (ack !== 1'h1)
      failures++;
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  // Compare one value
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts and verdict
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog against a hung link or bus
  initial
  begin
    #480000;
    failures++;
    give_verdict();
  end
  // Test sequence
  initial
  begin
    logic [31:0] q;
    logic [15:0] r;
    int n;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    bus(8'h00, 1'h0, 32'h0, q); check("ctrl1 reset", 32'h0, q);
    bus(8'h20, 1'h0, 32'h0, q); check("unmapped", 32'h0, q);
    i_host.period(n); check("frame", 32'd256, 32'(n));
    bus(8'h10, 1'h1, 32'h3, q);
    bus(8'h18, 1'h1, 32'hA5C3, q);
    i_host.period(n); check("frame", 32'd256, 32'(n));
    $display("test reset done");
    i_host.xfer(16'h1234, r); check("adc word", 32'hA5C3, {16'h0, r});
    bus(8'h1C, 1'h0, 32'h0, q); check("dac word", 32'h1234, q);
    i_host.pulse_req();
    i_host.gap(n); check("pin slot", 32'd110, 32'(n));
    i_host.xfer(16'h645A, r); check("write echo", 32'h6000, {16'h0, r});
    bus(8'h04, 1'h0, 32'h0, q); check("ctrl2", 32'h5A, q);
    bus(8'h14, 1'h0, 32'h0, q); check("flag clear", 32'h0, q);
    $display("test pin write done");
    i_host.xfer(16'h8001, r);
    i_host.gap(n); check("soft slot", 32'd112, 32'(n));
    i_host.xfer(16'h7400, r); check("read echo", 32'h605A, {16'h0, r});
    bus(8'h1C, 1'h0, 32'h0, q); check("dac raw", 32'h8001, q);
    bus(8'h04, 1'h0, 32'h0, q); check("ctrl2 kept", 32'h5A, q);
    $display("test soft read done");
    bus(8'h08, 1'h1, 32'h20, q);
    i_host.period(n);
    i_host.period(n); check("continuous", 32'd16, 32'(n));
    i_host.direct_config_serial_input(15'h383C);
    bus(8'h0C, 1'h0, 32'h0, q); check("ctrl4", 32'h3C, q);
    i_host.direct_config_serial_input(15'h3600);
    bus(8'h08, 1'h0, 32'h0, q); check("ctrl3", 32'h0, q);
    $display("test continuous done");
    bus(8'h00, 1'h1, 32'h1, q);
    bus(8'h10, 1'h1, 32'hB, q);
    i_host.xfer(16'h8001, r);
    i_host.period(n); check("big frame", 32'd512, 32'(n));
    $display("test wide mode done");
    give_verdict();
  end
endmodule
